// file: rtl/wide_timer_ctrl.sv
// wide timer control, reload and capture registers behind an apb slave
//
// The APB register port was decided locally.
`timescale 1ns/1ns

// What this block does
// (RL1) control bit 7 starts, stops, reports counting
// (RL2) bit 6: single pass or edge ignore
// (RL3) timeout flag bit 5, write one clears
// (RL4) bits 4:3 divide clock by 1/2/4/8
// (RL5) bit 2 gates the capture interrupt
// (RL6) bit 1 gates the timeout interrupt
// (RL7) bit 0 routes timer output to pin
// (RL8) high capture holds captured upper byte
// (RL9) low capture holds captured lower byte
// (RL10) high capture ignores writes, reads eight bits
// (RL11) low capture ignores writes, reads byte
// (RL12) high load byte read/write, reload upper
// (RL13) low load byte supplies reload lower
// (RL14) timeout raises flag, masked interrupt
module wide_timer_ctrl (
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire wide_timer_pkg::apb_req_s apb_req,
  output wide_timer_pkg::apb_rsp_s      apb_rsp,
  input  wire logic                     demod_mode,
  input  wire logic                     capture_in,
  input  wire logic                     gpio_out,
  input  wire logic                     gpio_oe_n,
  output logic                          timer_output_pin,
  output logic                          timer_output_pin_oe_n,
  output logic                          irq
);
  import wide_timer_pkg::*;

  typedef struct packed {
    logic [7:0]        ctrl;
    logic [7:0]        reload_lo;
    logic [7:0]        reload_hi;
    logic [7:0]        cap_lo;
    logic [7:0]        cap_hi;
    logic [15:0]       count;
    logic              timer_out;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic              pin_out;
    logic              pin_oe_n;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } ctrl_state_s;

  ctrl_state_s state_reg;
  ctrl_state_s state_next;

  logic              tick;
  logic              edge_pulse;
  logic              demod_sync1;
  logic              demod_sync2;
  logic              setup_phase;
  logic              wr_access;
  logic [3:0]        idx;
  logic              idx_ok;
  logic [DATA_W-1:0] rd_word;
  logic [15:0]       reload_word;
  logic              timeout_ev;
  logic              capture_ev;
  logic              start_wr;
  logic [IRQ_W-1:0]  irq_gate;

  wide_timer_prescaler u_prescaler (
    .mclk            (mclk),
    .rstn            (rstn),
    .prescale_select (state_reg.ctrl[CTL_PRE_HI:CTL_PRE_LO]),
    .tick            (tick)
  );

  wide_timer_edge_sync u_edge_sync (
    .mclk       (mclk),
    .rstn       (rstn),
    .async_in   (capture_in),
    .edge_pulse (edge_pulse)
  );

  // the mode strap comes from outside this clock domain
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      demod_sync1 <= 1'b0;
      demod_sync2 <= 1'b0;
    end else begin
      demod_sync1 <= demod_mode;
      demod_sync2 <= demod_sync1;
    end
  end

  // register index from a word-aligned byte address
  function automatic logic [3:0] addr_index(input logic [ADDR_W-1:0] addr);
    addr_index = addr[5:2];
  endfunction : addr_index

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    addr_mapped = (addr == byte_addr(IDX_CONTROL))     ||
                  (addr == byte_addr(IDX_RELOAD_LOW))  ||
                  (addr == byte_addr(IDX_RELOAD_HIGH)) ||
                  (addr == byte_addr(IDX_CAPTURE_LOW)) ||
                  (addr == byte_addr(IDX_CAPTURE_HI))  ||
                  (addr == byte_addr(IDX_IRQ_STATUS))  ||
                  (addr == byte_addr(IDX_IRQ_MASK));
  endfunction : addr_mapped

  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign wr_access   = apb_req.psel && apb_req.penable && apb_req.pwrite && idx_ok;
  assign idx         = addr_index(apb_req.paddr);
  assign idx_ok      = addr_mapped(apb_req.paddr);
  assign reload_word = {state_reg.reload_hi, state_reg.reload_lo};           // [RL13]
  assign start_wr    = wr_access && (idx == IDX_CONTROL) &&
                       apb_req.pwdata[CTL_RUN] && !state_reg.ctrl[CTL_RUN];

  // events of the counting datapath
  assign timeout_ev = state_reg.ctrl[CTL_RUN] && tick && !start_wr &&
                      (state_reg.count == RESET_COUNT);
  assign capture_ev = state_reg.ctrl[CTL_RUN] && demod_sync2 && edge_pulse &&
                      !state_reg.ctrl[CTL_SINGLE];                           // [RL2]

  // read mux; capture bytes are read-only copies of the last capture
  always_comb begin
    rd_word = '0;
    if (idx == IDX_CONTROL) begin
      rd_word[7:0] = state_reg.ctrl;                                         // [RL1]
    end else if (idx == IDX_RELOAD_LOW) begin
      rd_word[7:0] = state_reg.reload_lo;
    end else if (idx == IDX_RELOAD_HIGH) begin
      rd_word[7:0] = state_reg.reload_hi;                                    // [RL12]
    end else if (idx == IDX_CAPTURE_LOW) begin
      rd_word[7:0] = state_reg.cap_lo;                                       // [RL11]
    end else if (idx == IDX_CAPTURE_HI) begin
      rd_word[7:0] = state_reg.cap_hi;                                       // [RL10]
    end else if (idx == IDX_IRQ_STATUS) begin
      rd_word[IRQ_W-1:0] = state_reg.irq_status;
    end else if (idx == IDX_IRQ_MASK) begin
      rd_word[IRQ_W-1:0] = state_reg.irq_mask;
    end
  end

  always_comb begin
    state_next = state_reg;

    // read data and error are latched in the setup cycle for the access phase
    if (setup_phase) begin
      state_next.prdata  = addr_mapped(apb_req.paddr) ? rd_word : '0;
      state_next.pslverr = !addr_mapped(apb_req.paddr);
    end

    // software writes; writes to the capture bytes are dropped
    if (wr_access) begin
      if (idx == IDX_CONTROL) begin
        state_next.ctrl[CTL_RUN]               = apb_req.pwdata[CTL_RUN];    // [RL1]
        state_next.ctrl[CTL_SINGLE]            = apb_req.pwdata[CTL_SINGLE];
        state_next.ctrl[CTL_PRE_HI:CTL_PRE_LO] =
          apb_req.pwdata[CTL_PRE_HI:CTL_PRE_LO];                             // [RL4]
        state_next.ctrl[CTL_CAP_MASK]          = apb_req.pwdata[CTL_CAP_MASK];
        state_next.ctrl[CTL_TO_MASK]           = apb_req.pwdata[CTL_TO_MASK];
        state_next.ctrl[CTL_PIN_SEL]           = apb_req.pwdata[CTL_PIN_SEL];
        if (apb_req.pwdata[CTL_TIMEOUT]) begin
          state_next.ctrl[CTL_TIMEOUT] = 1'b0;                               // [RL3]
        end
      end else if (idx == IDX_RELOAD_LOW) begin
        state_next.reload_lo = apb_req.pwdata[7:0];                          // [RL13]
      end else if (idx == IDX_RELOAD_HIGH) begin
        state_next.reload_hi = apb_req.pwdata[7:0];                          // [RL12]
      end else if (idx == IDX_IRQ_STATUS) begin
        state_next.irq_status = state_reg.irq_status & ~apb_req.pwdata[IRQ_W-1:0];
      end else if (idx == IDX_IRQ_MASK) begin
        state_next.irq_mask = apb_req.pwdata[IRQ_W-1:0];
      end
    end

    // counting: load on start, count down per prescaled tick
    if (start_wr) begin
      state_next.count = reload_word;
    end else if (state_reg.ctrl[CTL_RUN] && capture_ev) begin
      // a capture restarts the measurement of the next interval
      state_next.count = reload_word;
    end else if (state_reg.ctrl[CTL_RUN] && tick) begin
      if (timeout_ev) begin
        state_next.count = reload_word;
      end else begin
        state_next.count = state_reg.count - 16'h0001;
      end
    end

    if (capture_ev) begin
      state_next.cap_hi = state_reg.count[15:8];                             // [RL8]
      state_next.cap_lo = state_reg.count[7:0];                              // [RL9]
      state_next.irq_status[IRQ_CAPTURE] = 1'b1;
    end

    // hardware set wins over a software clear in the same cycle
    if (timeout_ev) begin
      state_next.ctrl[CTL_TIMEOUT]       = 1'b1;                             // [RL14]
      state_next.irq_status[IRQ_TIMEOUT] = 1'b1;
      if (!demod_sync2) begin
        state_next.timer_out = !state_reg.timer_out;
      end
      if (!demod_sync2 && state_reg.ctrl[CTL_SINGLE]) begin
        state_next.ctrl[CTL_RUN] = 1'b0;                                     // [RL2]
      end
    end

    // pin mux, registered so the pad sees no decode glitches
    if (state_reg.ctrl[CTL_PIN_SEL]) begin
      state_next.pin_out  = state_reg.timer_out;                             // [RL7]
      state_next.pin_oe_n = 1'b0;
    end else begin
      state_next.pin_out  = gpio_out;
      state_next.pin_oe_n = gpio_oe_n;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg          <= '0;
      state_reg.pin_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // both the status mask and the control mask bits gate each source
  assign irq_gate = {state_reg.ctrl[CTL_CAP_MASK],                           // [RL5]
                     state_reg.ctrl[CTL_TO_MASK]};                           // [RL6]
  assign irq      = |(state_reg.irq_status & state_reg.irq_mask & irq_gate);  // [RL14]

  assign apb_rsp                = '{prdata:  state_reg.prdata,
                                    pready:  1'b1,
                                    pslverr: state_reg.pslverr};
  assign timer_output_pin       = state_reg.pin_out;
  assign timer_output_pin_oe_n  = state_reg.pin_oe_n;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  logic wr_ctrl;
  logic div8_sel;
  assign wr_ctrl  = wr_access && (idx == IDX_CONTROL);
  assign div8_sel = state_reg.ctrl[CTL_PRE_HI:CTL_PRE_LO] == PRE_DIV8;

  run_write_a: assert property ( // [RL1]
    wr_ctrl && !timeout_ev |=> state_reg.ctrl[CTL_RUN] == $past(apb_req.pwdata[CTL_RUN]))
    else $error("run bit does not follow the written value");

  single_stop_a: assert property ( // [RL2]
    timeout_ev && state_reg.ctrl[CTL_SINGLE] && !demod_sync2 |=> !state_reg.ctrl[CTL_RUN])
    else $error("single pass did not stop the counter");

  flag_clear_a: assert property ( // [RL3]
    wr_ctrl && apb_req.pwdata[CTL_TIMEOUT] && !timeout_ev |=> !state_reg.ctrl[CTL_TIMEOUT])
    else $error("timeout flag not cleared by writing one");

  flag_hold_a: assert property ( // [RL3]
    state_reg.ctrl[CTL_TIMEOUT] && !(wr_ctrl && apb_req.pwdata[CTL_TIMEOUT])
      |=> state_reg.ctrl[CTL_TIMEOUT])
    else $error("timeout flag lost without a clear");

  // a prescale change mid-window releases the check; the divider never rephases
  tick_rate_a: assert property ( // [RL4]
    tick && div8_sel |=> (!tick || !div8_sel) [*7] ##1 (tick || !div8_sel))
    else $error("divide by eight tick spacing wrong");

  cap_irq_gate_a: assert property ( // [RL5]
    !state_reg.ctrl[CTL_CAP_MASK] && !state_reg.irq_status[IRQ_TIMEOUT] |-> !irq)
    else $error("capture interrupt raised while masked");

  to_irq_a: assert property ( // [RL6]
    timeout_ev && state_reg.ctrl[CTL_TO_MASK] && state_reg.irq_mask[IRQ_TIMEOUT]
      && !wr_access |=> irq)
    else $error("unmasked timeout did not raise the interrupt");

  pin_route_a: assert property ( // [RL7]
    state_reg.ctrl[CTL_PIN_SEL] |=> !timer_output_pin_oe_n &&
      timer_output_pin == $past(state_reg.timer_out))
    else $error("timer output not routed to the pin");

  capture_value_a: assert property ( // [RL8]
    capture_ev |=> {state_reg.cap_hi, state_reg.cap_lo} == $past(state_reg.count))
    else $error("captured word differs from counter");

  capture_ro_a: assert property ( // [RL10]
    !capture_ev ##1 1'b1 |-> $stable(state_reg.cap_hi) && $stable(state_reg.cap_lo))
    else $error("capture bytes changed without a capture");

  reload_use_a: assert property ( // [RL12]
    start_wr |=> state_reg.count == $past(reload_word))
    else $error("counter not loaded from the reload word");

  timeout_flag_a: assert property ( // [RL14]
    timeout_ev |=> state_reg.ctrl[CTL_TIMEOUT] && state_reg.irq_status[IRQ_TIMEOUT])
    else $error("timeout did not raise the flag");

  unmapped_err_a: assert property (
    setup_phase && !idx_ok |=> apb_rsp.pslverr && apb_rsp.prdata == '0)
    else $error("unmapped address not answered with an error");

  // datapath checks, with the same exclusions as the next-state logic
  count_down_a: assert property ( // [RL4]
    state_reg.ctrl[CTL_RUN] && tick && !timeout_ev && !capture_ev && !start_wr
      |=> state_reg.count == $past(state_reg.count) - 16'h0001)
    else $error("counter did not step down on a tick");

  mod_reload_a: assert property ( // [RL2]
    timeout_ev && !state_reg.ctrl[CTL_SINGLE] && !demod_sync2 && !wr_ctrl
      |=> state_reg.ctrl[CTL_RUN] && state_reg.count == $past(reload_word))
    else $error("modulo count did not reload and keep running");

  to_irq_gate_a: assert property ( // [RL6]
    !state_reg.ctrl[CTL_TO_MASK] && !state_reg.irq_status[IRQ_CAPTURE] |-> !irq)
    else $error("timeout interrupt raised while masked");

  toggle_a: assert property ( // [RL7]
    timeout_ev && !demod_sync2 |=> state_reg.timer_out != $past(state_reg.timer_out))
    else $error("timer output did not toggle on timeout");

  pin_gpio_a: assert property ( // [RL7]
    !state_reg.ctrl[CTL_PIN_SEL] |=> timer_output_pin == $past(gpio_out) &&
      timer_output_pin_oe_n == $past(gpio_oe_n))
    else $error("pin not handed to the port logic");

  cap_lo_a: assert property ( // [RL9]
    capture_ev |=> state_reg.cap_lo == $past(state_reg.count[7:0]))
    else $error("low capture byte differs from counter");

  reload_low_a: assert property ( // [RL13]
    wr_access && idx == IDX_RELOAD_LOW |=> state_reg.reload_lo == $past(apb_req.pwdata[7:0]))
    else $error("low reload byte not written");

  status_clear_a: assert property (
    wr_access && idx == IDX_IRQ_STATUS && apb_req.pwdata[IRQ_CAPTURE] && !capture_ev
      |=> !state_reg.irq_status[IRQ_CAPTURE])
    else $error("capture status not cleared by writing one");

  timeout_seen_c: cover property (timeout_ev ##1 irq);
  capture_seen_c: cover property (capture_ev ##1 state_reg.irq_status[IRQ_CAPTURE]);
  single_pass_c:  cover property (start_wr ##[1:300] !state_reg.ctrl[CTL_RUN]);
  modulo_run_c:   cover property (timeout_ev ##1 state_reg.ctrl[CTL_RUN]);
  edge_ignored_c: cover property (edge_pulse && demod_sync2 && state_reg.ctrl[CTL_SINGLE]);

endmodule : wide_timer_ctrl

// file: include/wide_timer_pkg.sv
// register map, field layout and APB bus types of the wide timer control block
package wide_timer_pkg;

  // register indices; each register sits at byte address 4 * index
  localparam logic [3:0] IDX_CONTROL     = 4'h2;
  localparam logic [3:0] IDX_RELOAD_LOW  = 4'h6;
  localparam logic [3:0] IDX_RELOAD_HIGH = 4'h7;
  localparam logic [3:0] IDX_CAPTURE_LOW = 4'h8;
  localparam logic [3:0] IDX_CAPTURE_HI  = 4'h9;
  localparam logic [3:0] IDX_IRQ_STATUS  = 4'ha;
  localparam logic [3:0] IDX_IRQ_MASK    = 4'hb;

  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;

  // control register fields
  localparam int CTL_RUN      = 7;
  localparam int CTL_SINGLE   = 6;
  localparam int CTL_TIMEOUT  = 5;
  localparam int CTL_PRE_HI   = 4;
  localparam int CTL_PRE_LO   = 3;
  localparam int CTL_CAP_MASK = 2;
  localparam int CTL_TO_MASK  = 1;
  localparam int CTL_PIN_SEL  = 0;

  // interrupt status / mask fields
  localparam int IRQ_TIMEOUT  = 0;
  localparam int IRQ_CAPTURE  = 1;
  localparam int IRQ_W        = 2;

  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;

  // prescale codes and the divisor mask (divisor minus one) for each
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV2 = 2'h1;
  localparam logic [1:0] PRE_DIV4 = 2'h2;
  localparam logic [1:0] PRE_DIV8 = 2'h3;
  localparam logic [2:0] MASK_DIV1 = 3'h0;
  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV8 = 3'h7;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } apb_rsp_s;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [3:0] idx);
    byte_addr = {{(ADDR_W-6){1'b0}}, idx, 2'b00};
  endfunction : byte_addr

endpackage : wide_timer_pkg

// file: rtl/wide_timer_prescaler.sv
// prescaler: one-cycle tick at system clock divided by 1, 2, 4 or 8
`timescale 1ns/1ns
module wide_timer_prescaler (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [1:0] prescale_select,
  output logic            tick
);
  import wide_timer_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
  } pre_state_s;

  pre_state_s state_reg;
  pre_state_s state_next;
  logic [2:0] div_mask;

  always_comb begin
    case (prescale_select)
      PRE_DIV1: div_mask = MASK_DIV1;
      PRE_DIV2: div_mask = MASK_DIV2;
      PRE_DIV4: div_mask = MASK_DIV4;
      default:  div_mask = MASK_DIV8;
    endcase
    // free-running, so a new select takes effect within one divided period
    state_next     = state_reg;
    state_next.cnt = state_reg.cnt + 3'h1;
    tick           = ((state_reg.cnt & div_mask) == div_mask);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : wide_timer_prescaler

// file: rtl/wide_timer_edge_sync.sv
// two-stage synchroniser for the capture input, with an any-edge pulse
`timescale 1ns/1ns
module wide_timer_edge_sync (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      edge_pulse
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_s;

  sync_state_s state_reg;
  sync_state_s state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.meta = async_in;
    state_next.sync = state_reg.meta;
    state_next.prev = state_reg.sync;
    // only the second stage feeds the detector
    edge_pulse      = state_reg.sync ^ state_reg.prev;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : wide_timer_edge_sync

// file: dv/testbench.sv
// self-checking bench for the wide timer control block
`timescale 1ns/1ns
module testbench;
  import wide_timer_pkg::*;
  logic        mclk;
  logic        rstn;
  apb_req_s    apb_req;
  apb_rsp_s    apb_rsp;
  logic        demod_mode;
  logic        capture_in;
  logic        gpio_out;
  logic        gpio_oe_n;
  logic        timer_output_pin;
  logic        timer_output_pin_oe_n;
  logic        irq;
  logic        pin_was;
  logic        e;
  logic [31:0] v;
  logic [31:0] r;
  int          err_total;
  int          checks;
  int          n;
  int          d;
  int          ctrl_m;
  int          rl_m;
  int          rh_m;
  int          mask_m;
  int          stat_m;

  wide_timer_ctrl dut_u (
    .mclk                  (mclk),
    .rstn                  (rstn),
    .apb_req               (apb_req),
    .apb_rsp               (apb_rsp),
    .demod_mode            (demod_mode),
    .capture_in            (capture_in),
    .gpio_out              (gpio_out),
    .gpio_oe_n             (gpio_oe_n),
    .timer_output_pin      (timer_output_pin),
    .timer_output_pin_oe_n (timer_output_pin_oe_n),
    .irq                   (irq)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  function automatic logic mapped(input logic [3:0] idx);
    mapped = idx inside {IDX_CONTROL, IDX_RELOAD_LOW, IDX_RELOAD_HIGH, IDX_CAPTURE_LOW,
                         IDX_CAPTURE_HI, IDX_IRQ_STATUS, IDX_IRQ_MASK};
  endfunction : mapped

  // capture bytes stay zero in the model until the capture test reads them raw
  function automatic logic [31:0] mval(input logic [3:0] idx);
    case (idx)
      IDX_CONTROL:     mval = ctrl_m;
      IDX_RELOAD_LOW:  mval = rl_m;
      IDX_RELOAD_HIGH: mval = rh_m;
      IDX_IRQ_STATUS:  mval = stat_m;
      IDX_IRQ_MASK:    mval = mask_m;
      default:         mval = 32'h0;
    endcase
  endfunction : mval

  function automatic logic irq_m();
    irq_m = |(stat_m & mask_m & ((ctrl_m >> 1) & 3));
  endfunction : irq_m

  task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    k = 0;
    @(posedge mclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {6'h00, idx, 2'b00},
                 pwdata: wd};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 50);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (k >= 50) begin
      err_total++;
    end
  endtask : apb

  task automatic wr(input logic [3:0] idx, input logic [31:0] dat);
    logic [31:0] rr;
    logic        ee;
    apb(1'b1, idx, dat, rr, ee);
    chk({31'h0, ee}, {31'h0, ~mapped(idx)});
    case (idx)
      IDX_CONTROL:     ctrl_m = (dat & 32'hdf) | (ctrl_m & ~dat & 32'h20);
      IDX_RELOAD_LOW:  rl_m = dat & 32'hff;
      IDX_RELOAD_HIGH: rh_m = dat & 32'hff;
      IDX_IRQ_STATUS:  stat_m = stat_m & ~dat & 32'h3;
      IDX_IRQ_MASK:    mask_m = dat & 32'h3;
      default:         ;
    endcase
  endtask : wr

  task automatic rd(input logic [3:0] idx);
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, mval(idx));
    chk({31'h0, e}, {31'h0, ~mapped(idx)});
  endtask : rd

  // outputs are looked at on the falling edge, where the rising edge's updates have landed
  task automatic chk_irq();
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, irq_m()});
  endtask : chk_irq

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_irq

  task automatic count_toggles(input int cycles);
    repeat (2) @(negedge mclk);
    pin_was = timer_output_pin;
    n = 0;
    repeat (cycles) begin
      @(negedge mclk);
      n += (timer_output_pin !== pin_was);
      pin_was = timer_output_pin;
    end
  endtask : count_toggles

  initial begin
    #400000;
    err_total++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    apb_req = '0;
    demod_mode = 1'b0;
    capture_in = 1'b0;
    gpio_out = 1'b0;
    gpio_oe_n = 1'b1;
    err_total = 0;
    checks = 0;
    ctrl_m = 0;
    rl_m = 0;
    rh_m = 0;
    mask_m = 0;
    stat_m = 0;
    v = $urandom(32'hf498c678);
    repeat (12) @(posedge mclk);
    chk({31'h0, timer_output_pin_oe_n}, 32'h1);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(4'(i));
    end
    $display("test reset_map done");

    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      gpio_out <= v[9];
      gpio_oe_n <= v[10];
      wr(IDX_RELOAD_HIGH, v[7:0]);
      wr(IDX_RELOAD_LOW, v[15:8]);
      wr(IDX_CAPTURE_HI, v);
      wr(IDX_CAPTURE_LOW, v);
      wr(IDX_IRQ_MASK, v[17:16]);
      wr(4'hc, v);
      wr(IDX_CONTROL, v & 32'h5f);
      for (int k = 2; k < 10; k++) begin
        rd(4'(k));
      end
      @(negedge mclk);
      chk({31'h0, timer_output_pin_oe_n}, {31'h0, v[0] ? 1'b0 : v[10]});
      if (!v[0]) chk({31'h0, timer_output_pin}, {31'h0, v[9]});
    end
    $display("test register_rw done");

    wr(IDX_IRQ_MASK, 32'h3);
    for (int p = 0; p < 4; p++) begin
      d = 1 << p;
      wr(IDX_RELOAD_LOW, 32'h5);
      wr(IDX_RELOAD_HIGH, 32'h0);
      wr(IDX_CONTROL, 32'h21);
      repeat (2) @(negedge mclk);
      pin_was = timer_output_pin;
      wr(IDX_CONTROL, 32'hc3 | (p << 3));
      wait_irq();
      chk(n >= 5 * d + 1 && n <= 7 * d + 4, 1);
      ctrl_m = (ctrl_m & 32'h7f) | 32'h20;
      stat_m = stat_m | 1;
      chk_irq();
      rd(IDX_CONTROL);
      rd(IDX_IRQ_STATUS);
      chk({31'h0, timer_output_pin}, {31'h0, ~pin_was});
      wr(IDX_CONTROL, 32'h03);
      rd(IDX_CONTROL);
      wr(IDX_CONTROL, 32'h21);
      chk_irq();
      rd(IDX_CONTROL);
      wr(IDX_CONTROL, 32'h03);
      chk_irq();
      wr(IDX_IRQ_STATUS, 32'h1);
      chk_irq();
    end
    $display("test single_pass done");

    wr(IDX_RELOAD_LOW, 32'h3);
    wr(IDX_CONTROL, 32'h83);
    count_toggles(200);
    chk(n >= 47 && n <= 51, 1);
    ctrl_m = ctrl_m | 32'h20;
    stat_m = stat_m | 1;
    rd(IDX_CONTROL);
    wr(IDX_CONTROL, 32'h21);
    count_toggles(40);
    chk(n, 0);
    wr(IDX_IRQ_STATUS, 32'h3);
    $display("test modulo done");

    demod_mode <= 1'b1;
    wr(IDX_RELOAD_LOW, 32'h80);
    wr(IDX_RELOAD_HIGH, 32'hff);
    wr(IDX_CONTROL, 32'h9c);
    repeat (20) @(posedge mclk);
    capture_in <= 1'b1;
    wait_irq();
    stat_m = stat_m | 2;
    chk_irq();
    apb(1'b0, IDX_CAPTURE_HI, 32'h0, r, e);
    chk(r, 32'hff);
    apb(1'b0, IDX_CAPTURE_LOW, 32'h0, r, e);
    chk(r >= 32'h70 && r <= 32'h7f, 1);
    rd(IDX_IRQ_STATUS);
    wr(IDX_CONTROL, 32'h98);
    chk_irq();
    wr(IDX_IRQ_STATUS, 32'h2);
    wr(IDX_CONTROL, 32'hdc);
    capture_in <= 1'b0;
    repeat (20) @(posedge mclk);
    rd(IDX_IRQ_STATUS);
    $display("test capture done");
    end_sim();
  end
endmodule : testbench
